// ==== pmf_cmd_core.sv ====
`timescale 1ns/1ps
module pmf_cmd_core #(
  parameter int         NFAULT      = 4,
  parameter int         BUSY_CYCLES = 2500000
) (
  // System clock domain
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Link side, on the bus clock
  input  wire logic              link_clk,
  input  wire logic              req_valid,
  input  wire pmf_pkg::pmf_req_s req,
  output logic                   link_ready,
  output logic                   rsp_valid,
  output pmf_pkg::pmf_rsp_s      rsp,
  // Pins and analog levels
  input  wire logic              enable_input_pin,
  input  wire logic              feedback_pin,
  input  wire logic [NFAULT-1:0] fault_in,
  input  wire logic              overvoltage_release_select,
  // Nonvolatile programming result
  input  wire logic              nvm_prog_fail,
  // Alert, open drain
  output logic                   alert_out,
  output logic                   alert_oe_n,
  // Power stage control
  output logic                   low_side_hold,
  output logic                   latched_off,
  output logic                   switch_allow,
  output logic                   faults_ignored,
  output logic [NFAULT-1:0]      status_fault
);
  import pmf_pkg::*;

  initial begin
    if (NFAULT < 1 || NFAULT > 8) $error("NFAULT must be 1 to 8");
    if (BUSY_CYCLES < 1) $error("BUSY_CYCLES must be at least 1");
  end

  localparam int BW = $clog2(BUSY_CYCLES + 1);

  function automatic logic [7:0] cfg_code(input int i);
    case (i)
      IDX_LOCK:      cfg_code = CMD_WRITE_LOCK;
      IDX_OPERATION: cfg_code = CMD_OPERATION;
      IDX_ON_OFF:    cfg_code = CMD_ON_OFF_CONFIG;
      IDX_VOUT:      cfg_code = CMD_VOUT_COMMAND;
      default:       cfg_code = CMD_VOUT_MAX;
    endcase
  endfunction

  // True when the level blocks writes to the code
  function automatic logic blocked(input logic [7:0] code, input logic [7:0] lock);
    blocked = 1'b0;
    if (code != CMD_WRITE_LOCK) begin
      if (lock[LOCK_ALL_BIT])                                          // [R12]
        blocked = 1'b1;
      else if (lock[LOCK_OP_BIT])                                      // [R11]
        blocked = (code != CMD_OPERATION);
      else if (lock[LOCK_CTRL_BIT])                                    // [R10]
        blocked = (code != CMD_OPERATION) && (code != CMD_ON_OFF_CONFIG) && (code != CMD_VOUT_COMMAND);
    end
  endfunction

  // Link domain: request held stable while a toggle crosses
  pmf_req_s req_hold;
  logic     req_tog;
  logic     pend;
  logic     rtog_s1;
  logic     rtog_s2;
  logic     rtog_seen;
  pmf_rsp_s rsp_reg;
  logic     rsp_tog;

  assign link_ready = ~pend;

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      req_hold  <= '0;
      req_tog   <= 1'b0;
      pend      <= 1'b0;
      rtog_s1   <= 1'b0;
      rtog_s2   <= 1'b0;
      rtog_seen <= 1'b0;
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rtog_s1   <= rsp_tog;
      rtog_s2   <= rtog_s1;
      rsp_valid <= 1'b0;
      if (rtog_s2 != rtog_seen) begin
        rtog_seen <= rtog_s2;
        pend      <= 1'b0;
        rsp_valid <= 1'b1;
        rsp       <= rsp_reg;
      end else if (req_valid && !pend) begin
        req_hold <= req;
        req_tog  <= ~req_tog;
        pend     <= 1'b1;
      end
    end
  end

  // System domain synchronisers
  logic              qtog_s1;
  logic              qtog_s2;
  logic              qtog_seen;
  logic              enable_input_pin_s1;
  logic              enable_input_pin_s2;
  logic              fb_s1;
  logic              fb_s2;
  logic [NFAULT-1:0] flt_s1;
  logic [NFAULT-1:0] flt_s2;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      qtog_s1 <= 1'b0;
      qtog_s2 <= 1'b0;
      // Pin idle level, so no false toggle follows reset
      enable_input_pin_s1 <= 1'b1;
      enable_input_pin_s2 <= 1'b1;
      fb_s1   <= 1'b0;
      fb_s2   <= 1'b0;
      flt_s1  <= '0;
      flt_s2  <= '0;
    end else if (clk_en) begin
      qtog_s1 <= req_tog;
      qtog_s2 <= qtog_s1;
      enable_input_pin_s1 <= enable_input_pin;
      enable_input_pin_s2 <= enable_input_pin_s1;
      fb_s1   <= feedback_pin;
      fb_s2   <= fb_s1;
      flt_s1  <= fault_in;
      flt_s2  <= flt_s1;
    end
  end

  // Control pin toggle: low long enough, then high again
  logic [ENABLE_INPUT_PIN_CNT_W-1:0] enable_input_pin_low_cnt;
  logic                  enable_input_pin_clear;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      enable_input_pin_low_cnt <= '0;
    end else if (clk_en) begin
      if (enable_input_pin_s2)
        enable_input_pin_low_cnt <= '0;
      else if (enable_input_pin_low_cnt < ENABLE_INPUT_PIN_CNT_W'(ENABLE_INPUT_PIN_LOW_CYCLES))
        enable_input_pin_low_cnt <= enable_input_pin_low_cnt + 1'b1;
    end
  end

  assign enable_input_pin_clear = enable_input_pin_s2 && (enable_input_pin_low_cnt >= ENABLE_INPUT_PIN_CNT_W'(ENABLE_INPUT_PIN_LOW_CYCLES)); // [R7]

  // Command sequencer
  pmf_state_e state;
  logic [BW-1:0] busy_cnt;
  logic [7:0]    cfg   [NCFG];
  logic [7:0]    image [NCFG];
  logic [7:0]    status_byte;
  logic [7:0]    status_cml;
  logic          new_req;
  logic          do_clear;
  logic          set_cml;
  logic          set_data;
  logic          set_mem;
  logic          prog_bad;

  assign new_req  = clk_en && (state == PMF_IDLE) && (qtog_s2 != qtog_seen);
  assign do_clear = (new_req && req_hold.write && req_hold.code == CMD_CLEAR_FAULTS) || enable_input_pin_clear;
  assign faults_ignored = (state == PMF_STORE);                           // [R17]
  assign switch_allow   = (state != PMF_RESTORE) && !latched_off;         // [R21]

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state     <= PMF_IDLE;
      busy_cnt  <= '0;
      qtog_seen <= 1'b0;
      rsp_tog   <= 1'b0;
      rsp_reg   <= '0;
      set_cml   <= 1'b0;
      set_data  <= 1'b0;
      set_mem   <= 1'b0;
      prog_bad  <= 1'b0;
      cfg[IDX_LOCK]       <= RST_LOCK;
      cfg[IDX_OPERATION]  <= RST_OPERATION;
      cfg[IDX_ON_OFF]     <= RST_ON_OFF;
      cfg[IDX_VOUT]       <= RST_VOUT;
      cfg[IDX_VOUT_MAX]   <= RST_VOUT_MAX;
      image[IDX_LOCK]     <= RST_LOCK;
      image[IDX_OPERATION]<= RST_OPERATION;
      image[IDX_ON_OFF]   <= RST_ON_OFF;
      image[IDX_VOUT]     <= RST_VOUT;
      image[IDX_VOUT_MAX] <= RST_VOUT_MAX;
    end else if (clk_en) begin
      set_cml  <= 1'b0;
      set_data <= 1'b0;
      set_mem  <= 1'b0;
      case (state)
        PMF_IDLE: begin
          if (new_req) begin
            qtog_seen     <= qtog_s2;
            rsp_reg.ack   <= 1'b1;
            rsp_reg.rdata <= 8'h00;
            if (!req_hold.write) begin
              case (req_hold.code)                                        // [R8]
                CMD_FEATURE:      rsp_reg.rdata <= FEATURE_VALUE;         // [R23]
                CMD_STATUS_BYTE:  rsp_reg.rdata <= status_byte;
                CMD_STATUS_CML:   rsp_reg.rdata <= status_cml;
                CMD_STATUS_FAULT: rsp_reg.rdata <= 8'(status_fault);
                default: begin
                  rsp_reg.ack <= 1'b0;
                  for (int i = 0; i < NCFG; i++) begin
                    if (req_hold.code == cfg_code(i)) begin
                      rsp_reg.ack   <= 1'b1;
                      rsp_reg.rdata <= cfg[i];
                    end
                  end
                end
              endcase
              rsp_tog <= ~rsp_tog;
            end else begin
              case (req_hold.code)
                CMD_CLEAR_FAULTS: rsp_tog <= ~rsp_tog;
                CMD_WRITE_LOCK: begin
                  if ((req_hold.data[LOCK_ALL_BIT] + req_hold.data[LOCK_OP_BIT]
                       + req_hold.data[LOCK_CTRL_BIT]) > 2'd1) begin
                    cfg[IDX_LOCK] <= 8'h00;                               // [R14]
                    set_cml       <= 1'b1;                                // [R13]
                    set_data      <= 1'b1;
                    rsp_reg.ack   <= 1'b0;
                  end else begin
                    cfg[IDX_LOCK] <= req_hold.data & LOCK_MASK;
                  end
                  rsp_tog <= ~rsp_tog;
                end
                CMD_STORE_ALL: begin                                      // [R22]
                  for (int i = 0; i < NCFG; i++)
                    image[i] <= cfg[i];                                   // [R16] [R15]
                  prog_bad <= nvm_prog_fail;
                  busy_cnt <= BW'(BUSY_CYCLES);
                  state    <= PMF_STORE;                                  // [R18]
                end
                CMD_RESTORE_ALL: begin                                    // [R22]
                  for (int i = 0; i < NCFG; i++)
                    if (!blocked(cfg_code(i), cfg[IDX_LOCK]))
                      cfg[i] <= image[i];                                 // [R20] [R9]
                  busy_cnt <= BW'(BUSY_CYCLES);
                  state    <= PMF_RESTORE;                                // [R18] [R21]
                end
                default: begin
                  rsp_reg.ack <= 1'b0;
                  set_cml     <= 1'b1;
                  for (int i = 1; i < NCFG; i++) begin
                    if (req_hold.code == cfg_code(i)) begin
                      if (blocked(req_hold.code, cfg[IDX_LOCK])) begin
                        rsp_reg.ack <= 1'b0;                              // [R24]
                      end else begin
                        cfg[i]      <= req_hold.data;
                        rsp_reg.ack <= 1'b1;
                        set_cml     <= 1'b0;
                      end
                    end
                  end
                  rsp_tog <= ~rsp_tog;
                end
              endcase
            end
          end
        end
        PMF_STORE, PMF_RESTORE: begin
          if (busy_cnt > BW'(1)) begin
            busy_cnt <= busy_cnt - 1'b1;
          end else begin
            busy_cnt      <= '0;
            state         <= PMF_IDLE;
            rsp_reg.ack   <= !(state == PMF_STORE && prog_bad);           // [R19]
            rsp_reg.rdata <= 8'h00;
            set_cml       <= (state == PMF_STORE) && prog_bad;            // [R19]
            set_mem       <= (state == PMF_STORE) && prog_bad;
            prog_bad      <= 1'b0;
            rsp_tog       <= ~rsp_tog;
          end
        end
        default: state <= PMF_IDLE;
      endcase
    end
  end

  // Sticky status: a set in the clearing cycle wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      status_fault <= '0;
      status_byte  <= 8'h00;
      status_cml   <= 8'h00;
    end else if (clk_en) begin
      if (do_clear) begin                                                 // [R1]
        status_fault <= faults_ignored ? '0 : flt_s2;                     // [R4]
        status_byte  <= 8'h00;
        status_cml   <= 8'h00;
      end else if (!faults_ignored) begin
        status_fault <= status_fault | flt_s2;                            // [R4]
      end
      if (set_cml)
        status_byte[SB_CML_BIT] <= 1'b1;                                  // [R13]
      if (set_data)
        status_cml[CML_DATA_BIT] <= 1'b1;
      if (set_mem)
        status_cml[CML_MEM_BIT] <= 1'b1;                                  // [R19]
      // Only a live fault re-sets the summary bit, so a clear can drop it
      if (!faults_ignored && (|flt_s2))
        status_byte[SB_FAULT_BIT] <= 1'b1;                                // [R4]
    end
  end

  // Alert pulls low while any status bit is set
  logic alert_active;
  assign alert_active = (|status_fault) || (|status_byte) || (|status_cml);
  assign alert_out    = 1'b0;
  assign alert_oe_n   = ~alert_active;                                    // [R2] [R4]

  // Overvoltage latch on fault input 0; CLEAR_FAULTS never lifts latch-off, only the pin toggle does
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_side_hold <= 1'b0;
      latched_off   <= 1'b0;
    end else if (clk_en) begin
      if (flt_s2[0] && !faults_ignored) begin
        low_side_hold <= 1'b1;                                            // [R6]
        latched_off   <= 1'b1;
      end else begin
        if (overvoltage_release_select ? fb_s2 : do_clear)
          low_side_hold <= 1'b0;                                          // [R6]
        if (enable_input_pin_clear)
          latched_off <= 1'b0;                                            // [R3]
      end
    end
  end

endmodule

// ==== pmf_pkg.sv ====
// Function
// R1 - CLEAR_FAULTS clears every bit of every status register at once.
// R2 - CLEAR_FAULTS releases the alert output together with the status bits.
// R3 - CLEAR_FAULTS never restarts a converter latched off by a fault.
// R4 - A fault still present after clearing sets its bit again and alerts.
// R5 - Host waits 8 x rise time plus delay after shutdown before clearing.
// R6 - Overvoltage latch holds low-side switch; release by feedback or CLEAR_FAULTS.
// R7 - Control pin low over 100 ns then high clears faults.
// R8 - Every supported command stays readable whatever the protection level.
// R9 - Protected registers keep their values across a restore.
// R10 - Level bit5 allows writes only to protect, operation, on/off, vout.
// R11 - Level bit6 allows writes only to protect and operation.
// R12 - Level bit7 allows writes only to the protect register.
// R13 - Protect write with several level bits sets alert and comm fault flag.
// R14 - An invalid multi-bit protect value leaves no protection in effect.
// R15 - The protect setting is among the stored nonvolatile values.
// R16 - Store copies all storable settings to nonvolatile memory as defaults.
// R17 - During a store, switching continues but faults are ignored.
// R18 - After store or restore the bus gets no answer for about 100 ms.
// R19 - Failed programming: no acknowledge, comm fault and memory fault flags set.
// R20 - Restore reloads only registers the current protection leaves open.
// R21 - Restore while switching stops and later restarts the converter.
// R22 - User store and restore share codes and behaviour with default ones.
// R23 - Feature byte reports error checking, 400 kHz and alert response support.
// R24 - A blocked write leaves the stored value unchanged.
package pmf_pkg;
  localparam logic [7:0] CMD_OPERATION     = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CMD_WRITE_LOCK    = 8'h10;
  localparam logic [7:0] CMD_STORE_ALL     = 8'h11;
  localparam logic [7:0] CMD_RESTORE_ALL   = 8'h12;
  localparam logic [7:0] CMD_FEATURE       = 8'h19;
  localparam logic [7:0] CMD_VOUT_COMMAND  = 8'h21;
  localparam logic [7:0] CMD_VOUT_MAX      = 8'h24;
  localparam logic [7:0] CMD_STATUS_BYTE   = 8'h78;
  localparam logic [7:0] CMD_STATUS_FAULT  = 8'h7A;
  localparam logic [7:0] CMD_STATUS_CML    = 8'h7E;
  // Feature byte: error checking, 400 kHz speed field, alert support field
  localparam logic [7:0] FEATURE_VALUE     = 8'hB0;
  // Protection level bits
  localparam int         LOCK_ALL_BIT      = 7;
  localparam int         LOCK_OP_BIT       = 6;
  localparam int         LOCK_CTRL_BIT     = 5;
  localparam logic [7:0] LOCK_MASK         = 8'hE0;
  // Status bit positions
  localparam int         SB_CML_BIT        = 1;
  localparam int         SB_FAULT_BIT      = 0;
  localparam int         CML_DATA_BIT      = 6;
  localparam int         CML_MEM_BIT       = 4;
  // Storable settings: index and reset value
  localparam int         NCFG              = 5;
  localparam int         IDX_LOCK          = 0;
  localparam int         IDX_OPERATION     = 1;
  localparam int         IDX_ON_OFF        = 2;
  localparam int         IDX_VOUT          = 3;
  localparam int         IDX_VOUT_MAX      = 4;
  localparam logic [7:0] RST_LOCK          = 8'h00;
  localparam logic [7:0] RST_OPERATION     = 8'h00;
  localparam logic [7:0] RST_ON_OFF        = 8'h16;
  localparam logic [7:0] RST_VOUT          = 8'h00;
  localparam logic [7:0] RST_VOUT_MAX      = 8'hFF;
  // Timing
  localparam longint     MCLK_HZ           = 25_000_000;
  localparam longint     MCLK_PERIOD_NS    = 40;
  localparam longint     BUSY_TIME_MS      = 100;
  localparam longint     BUSY_CYCLES       = BUSY_TIME_MS * MCLK_HZ / 1000;
  localparam longint     ENABLE_INPUT_PIN_LOW_NS       = 100;
  // Samples a legal low pulse is sure to give; rounding up could miss a legal pulse
  localparam longint     ENABLE_INPUT_PIN_LOW_CYCLES   = ENABLE_INPUT_PIN_LOW_NS / MCLK_PERIOD_NS;
  localparam int         ENABLE_INPUT_PIN_CNT_W        = 4;

  typedef struct packed {
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } pmf_req_s;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } pmf_rsp_s;

  typedef enum logic [1:0] {PMF_IDLE, PMF_STORE, PMF_RESTORE} pmf_state_e;
endpackage

// ==== pmf_asserts.sv ====
`timescale 1ns/1ps
module pmf_asserts
  import pmf_pkg::*;
#(
  parameter int NFAULT = 4
) (
  // System domain
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              clk_en,
  // Link domain
  input wire logic              link_clk,
  input wire logic              req_valid,
  input wire pmf_pkg::pmf_req_s req,
  input wire logic              link_ready,
  input wire logic              rsp_valid,
  input wire pmf_pkg::pmf_rsp_s rsp,
  // Pins and power stage
  input wire logic              enable_input_pin,
  input wire logic              feedback_pin,
  input wire logic [NFAULT-1:0] fault_in,
  input wire logic              overvoltage_release_select,
  input wire logic              nvm_prog_fail,
  input wire logic              alert_out,
  input wire logic              alert_oe_n,
  input wire logic              low_side_hold,
  input wire logic              latched_off,
  input wire logic              switch_allow,
  input wire logic              faults_ignored,
  input wire logic [NFAULT-1:0] status_fault
);
  // Cycles since the control pin was last seen low, saturating
  logic [3:0] since_low;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      since_low <= 4'hF;
    end else if (!enable_input_pin) begin
      since_low <= 4'h0;
    end else if (since_low != 4'hF) begin
      since_low <= since_low + 4'h1;
    end
  end

  alert_on_fault_a: assert property (@(posedge mclk) disable iff (reset)
    (|status_fault) |-> ##[0:1] !alert_oe_n) else $error("alert not driven with fault set");
  latch_release_a: assert property (@(posedge mclk) disable iff (reset)
    $fell(latched_off) |-> since_low < 4'hC) else $error("latch left without pin toggle");
  latch_stops_a: assert property (@(posedge mclk) disable iff (reset)
    latched_off |-> !switch_allow) else $error("switching while latched off");
  store_runs_a: assert property (@(posedge mclk) disable iff (reset)
    faults_ignored && !latched_off |-> switch_allow) else $error("store stopped switching");
  store_mute_a: assert property (@(posedge mclk) disable iff (reset)
    faults_ignored && $past(faults_ignored) |-> $stable(status_fault)) else $error("fault taken during store");
  ov_hold_a: assert property (@(posedge mclk) disable iff (reset)
    $rose(fault_in[0]) && !faults_ignored && !overvoltage_release_select |-> ##[1:4] low_side_hold)
    else $error("low side not held on overvoltage");
  fb_release_a: assert property (@(posedge mclk) disable iff (reset)
    low_side_hold && overvoltage_release_select && feedback_pin && !fault_in[0] |-> ##[1:5] !low_side_hold)
    else $error("low side not released by feedback");
  clear_release_a: assert property (@(posedge mclk) disable iff (reset)
    $fell(low_side_hold) && !overvoltage_release_select |-> !status_fault[0])
    else $error("low side released without clear");
  link_busy_a: assert property (@(posedge link_clk) disable iff (reset)
    req_valid && link_ready |=> !link_ready [*2]) else $error("link ready during command");
endmodule

bind pmf_cmd_core pmf_asserts #(.NFAULT(NFAULT)) u_pmf_asserts (
  .mclk(mclk), .reset(reset), .clk_en(clk_en), .link_clk(link_clk), .req_valid(req_valid),
  .req(req), .link_ready(link_ready), .rsp_valid(rsp_valid), .rsp(rsp),
  .enable_input_pin(enable_input_pin), .feedback_pin(feedback_pin), .fault_in(fault_in),
  .overvoltage_release_select(overvoltage_release_select), .nvm_prog_fail(nvm_prog_fail),
  .alert_out(alert_out), .alert_oe_n(alert_oe_n), .low_side_hold(low_side_hold),
  .latched_off(latched_off), .switch_allow(switch_allow), .faults_ignored(faults_ignored),
  .status_fault(status_fault)
);

// ==== pmf_host.sv ====
`timescale 1ns/1ps
module pmf_host
  import pmf_pkg::*;
(
  // Link side
  input  wire logic              link_clk,
  input  wire logic              link_ready,
  input  wire logic              rsp_valid,
  input  wire pmf_pkg::pmf_rsp_s rsp,
  output pmf_pkg::pmf_req_s      req,
  output logic                   req_valid,
  // Control pin
  output logic                   enable_input_pin
);
  initial begin
    req_valid = 1'b0;
    req = '0;
    enable_input_pin = 1'b1;
  end

  // One command in flight; the request is held until link_ready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                      output pmf_rsp_s r, output int n);
    r = 'x;
    n = 0;
    @(posedge link_clk);
    #1;
    req_valid = 1'b1;
    req = '{write: w, code: c, data: d};
    do @(posedge link_clk); while (link_ready !== 1'b1);
    #1;
    req_valid = 1'b0;
    // Released lines show the inverse so stale data cannot pass
    req = ~req;
    while (n < 4000 && rsp_valid !== 1'b1) begin
      @(posedge link_clk);
      n++;
    end
    if (rsp_valid === 1'b1) r = rsp;
  endtask

  // Low time well over the minimum the device needs to see
  task automatic pulse_pin(input int low_ns);
    enable_input_pin = 1'b0;
    #(low_ns);
    enable_input_pin = 1'b1;
  endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import pmf_pkg::*;
  localparam int BUSY = 40;
  logic             mclk = 1'b0;
  logic             link_clk = 1'b0;
  logic             reset = 1'b1;
  logic             req_valid;
  pmf_req_s         req;
  logic             link_ready;
  logic             rsp_valid;
  pmf_rsp_s         rsp;
  logic             enable_input_pin;
  logic             feedback_pin = 1'b0;
  logic [3:0]       fault_in = 4'h0;
  logic             ov_sel = 1'b0;
  logic             nvm_prog_fail = 1'b0;
  logic             alert_out;
  logic             alert_oe_n;
  logic             low_side_hold;
  logic             latched_off;
  logic             switch_allow;
  logic             faults_ignored;
  logic [3:0]       status_fault;
  pmf_rsp_s         r;
  int               n;
  int               error_cnt = 0;
  int               n_tests = 0;
  logic [7:0]       d;
  logic [7:0]       cmd_c [4] = '{CMD_OPERATION, CMD_ON_OFF_CONFIG, CMD_VOUT_COMMAND, CMD_VOUT_MAX};
  logic [7:0]       mdl [4] = '{RST_OPERATION, RST_ON_OFF, RST_VOUT, RST_VOUT_MAX};
  logic [7:0]       lv [3] = '{8'h20, 8'h40, 8'h80};
  logic [3:0]       al [3] = '{4'b0111, 4'b0001, 4'b0000};

  always #20 mclk = ~mclk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  pmf_cmd_core #(.NFAULT(4), .BUSY_CYCLES(BUSY)) dut (
    .mclk(mclk), .reset(reset), .clk_en(1'b1), .link_clk(link_clk), .req_valid(req_valid),
    .req(req), .link_ready(link_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .enable_input_pin(enable_input_pin), .feedback_pin(feedback_pin), .fault_in(fault_in),
    .overvoltage_release_select(ov_sel), .nvm_prog_fail(nvm_prog_fail), .alert_out(alert_out),
    .alert_oe_n(alert_oe_n), .low_side_hold(low_side_hold), .latched_off(latched_off),
    .switch_allow(switch_allow), .faults_ignored(faults_ignored), .status_fault(status_fault));

  pmf_host host (
    .link_clk(link_clk), .link_ready(link_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .req(req), .req_valid(req_valid), .enable_input_pin(enable_input_pin));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic rd(input logic [7:0] c, input logic [8:0] e);
    host.xfer(1'b0, c, 8'h00, r, n);
    chk($sformatf("read %h", c), r, e);
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] v, input logic a);
    host.xfer(1'b1, c, v, r, n);
    chk($sformatf("ack %h", c), r.ack, a);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    tick(8);
    reset = 1'b0;
    rd(CMD_FEATURE, 9'h1B0);
    wr(CMD_FEATURE, 8'h00, 1'b0);
    rd(CMD_WRITE_LOCK, 9'h100);
    for (int i = 0; i < 4; i++) rd(cmd_c[i], {1'b1, mdl[i]});
    $display("test reset done");
    for (int l = 0; l < 3; l++) begin
      wr(CMD_WRITE_LOCK, lv[l], 1'b1);
      for (int i = 0; i < 4; i++) begin
        d = 8'(8'h21 * (l + 1) + i);
        wr(cmd_c[i], d, al[l][i]);
        if (al[l][i]) mdl[i] = d;
        rd(cmd_c[i], {1'b1, mdl[i]});
      end
    end
    wr(CMD_WRITE_LOCK, 8'h00, 1'b1);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    wr(CMD_WRITE_LOCK, 8'hA0, 1'b0);
    rd(CMD_WRITE_LOCK, 9'h100);
    rd(CMD_STATUS_BYTE, 9'h102);
    rd(CMD_STATUS_CML, 9'h140);
    chk("alert", alert_oe_n, 1'b0);
    wr(CMD_VOUT_MAX, 8'hC0, 1'b1);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("alert", alert_oe_n, 1'b1);
    chk("alert level", alert_out, 1'b0);
    rd(CMD_STATUS_BYTE, 9'h100);
    rd(CMD_STATUS_CML, 9'h100);
    $display("test protect done");
    fault_in = 4'h4;
    tick(8);
    chk("status", status_fault, 4'h4);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("status", status_fault, 4'h4);
    chk("alert", alert_oe_n, 1'b0);
    fault_in = 4'h0;
    tick(4);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("status", status_fault, 4'h0);
    $display("test persist done");
    fault_in = 4'h1;
    tick(8);
    fault_in = 4'h0;
    feedback_pin = 1'b1;
    tick(8);
    chk("hold", low_side_hold, 1'b1);
    #2000; // Settle time after shutdown before clearing
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("hold", low_side_hold, 1'b0);
    chk("latched", latched_off, 1'b1);
    host.pulse_pin(200);
    tick(8);
    chk("latched", latched_off, 1'b0);
    ov_sel = 1'b1;
    feedback_pin = 1'b0;
    fault_in = 4'h1;
    tick(8);
    fault_in = 4'h0;
    tick(8);
    chk("hold", low_side_hold, 1'b1);
    feedback_pin = 1'b1;
    tick(8);
    chk("hold", low_side_hold, 1'b0);
    ov_sel = 1'b0;
    host.pulse_pin(120);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    chk("latched", latched_off, 1'b0);
    $display("test overvoltage done");
    wr(CMD_VOUT_MAX, 8'h33, 1'b1);
    wr(CMD_OPERATION, 8'h80, 1'b1);
    wr(CMD_WRITE_LOCK, 8'h20, 1'b1);
    fork
      host.xfer(1'b1, CMD_STORE_ALL, 8'h00, r, n);
      begin
        tick(6);
        fault_in = 4'h8;
        tick(4);
        chk("ignored", faults_ignored, 1'b1);
        chk("switch", switch_allow, 1'b1);
        fault_in = 4'h0;
      end
    join
    chk("store ack", r.ack, 1'b1);
    chk("store wait", n >= 260, 1'b1);
    chk("status", status_fault, 4'h0);
    wr(CMD_OPERATION, 8'h00, 1'b1);
    wr(CMD_WRITE_LOCK, 8'h00, 1'b1);
    wr(CMD_VOUT_MAX, 8'h44, 1'b1);
    wr(CMD_WRITE_LOCK, 8'h40, 1'b1);
    fork
      host.xfer(1'b1, CMD_RESTORE_ALL, 8'h00, r, n);
      begin
        tick(8);
        chk("switch", switch_allow, 1'b0);
      end
    join
    chk("restore ack", r.ack, 1'b1);
    chk("restore wait", n >= 260, 1'b1);
    rd(CMD_OPERATION, 9'h180);
    rd(CMD_VOUT_MAX, 9'h144);
    rd(CMD_WRITE_LOCK, 9'h120);
    chk("switch", switch_allow, 1'b1);
    $display("test nonvolatile done");
    wr(CMD_WRITE_LOCK, 8'h00, 1'b1);
    tick(1);
    nvm_prog_fail = 1'b1;
    wr(CMD_STORE_ALL, 8'h00, 1'b0);
    tick(1);
    nvm_prog_fail = 1'b0;
    rd(CMD_STATUS_CML, 9'h110);
    rd(CMD_STATUS_BYTE, 9'h102);
    wr(CMD_CLEAR_FAULTS, 8'h00, 1'b1);
    $display("test store fail done");
    tally_and_finish;
  end
endmodule
